// [verilog/qcc_pkg.sv]
// qcc_pkg: shared constants and types for the counter channel and its host end
// assumes: one clock, synchronous active-low reset on both ends
package qcc_pkg;

  localparam int unsigned CNT_W          = 32;
  localparam int unsigned CFG_W          = 16;

  // ---------------------------------------------------------------
  // counter type encoding
  // ---------------------------------------------------------------
  localparam logic        TYPE_CIRCULAR  = 1'b0;
  localparam logic        TYPE_LINEAR    = 1'b1;

  // ---------------------------------------------------------------
  // output mode encoding
  // ---------------------------------------------------------------
  localparam logic        OUT_AUTO       = 1'b0;
  localparam logic        OUT_MANUAL     = 1'b1;

  // ---------------------------------------------------------------
  // limits and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CIRC_MAX       = 32'hFFFF_FFFF;
  localparam logic [31:0] LIN_MAX        = 32'h7FFF_FFFF;
  localparam logic [31:0] LIN_MIN        = 32'h8000_0000;
  localparam logic [31:0] ZERO32         = 32'h0000_0000;
  localparam logic [31:0] ONE32          = 32'h0000_0001;

  // ---------------------------------------------------------------
  // configuration word fields
  // ---------------------------------------------------------------
  localparam int unsigned CFG_IDX_LSB    = 0;
  localparam int unsigned CFG_IDX_MSB    = 3;
  localparam int unsigned CFG_ERR_LSB    = 4;
  localparam int unsigned CFG_ERR_MSB    = 7;
  localparam logic [3:0]  CFG_FIELD_ON   = 4'h1;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // count step encoding
  typedef enum logic [1:0] {
    QCC_STEP_NONE = 2'b00,
    QCC_STEP_UP   = 2'b01,
    QCC_STEP_DOWN = 2'b10
  } qcc_step_t;

  // host-side command sequence
  typedef enum logic [2:0] {
    QCC_H_IDLE  = 3'b001,
    QCC_H_ARM   = 3'b010,
    QCC_H_CLEAR = 3'b100
  } qcc_hstate_t;

endpackage

// [verilog/qcc_if.sv]
// qcc_if: variable exchange between host controller and counter channel
// assumes: refresh is a one-cycle strobe driven by the host end
`timescale 1ns/1ps
interface qcc_if;
  import qcc_pkg::*;
  logic              refresh;
  logic              load_preset_cmd;
  logic              clear_count_cmd;
  logic [CNT_W-1:0]  load_value_signed;
  logic              count_type_select;
  logic [CNT_W-1:0]  high_limit_setting;
  logic [CNT_W-1:0]  low_limit_setting;
  logic [CFG_W-1:0]  index_and_errgen_cfg;
  logic              out_mode_select;
  logic              dout0_manual_level;
  logic              dout1_manual_level;
  logic              err_dout0_level;
  logic              err_dout1_level;
  logic              auto_dout0_level;
  logic              auto_dout1_level;
  logic [CNT_W-1:0]  signed_count_value;
  logic [CNT_W-1:0]  wrap_count_value;
  logic              above_limit_flag;
  logic              below_limit_flag;
  logic              din0_level;
  logic              din1_level;
  logic              dout0_state;
  logic              dout1_state;
  logic              err_code_valid;
  modport dev (
    input  refresh, load_preset_cmd, clear_count_cmd, load_value_signed, count_type_select,
           high_limit_setting, low_limit_setting, index_and_errgen_cfg, out_mode_select,
           dout0_manual_level, dout1_manual_level, err_dout0_level, err_dout1_level,
           auto_dout0_level, auto_dout1_level,
    output signed_count_value, wrap_count_value, above_limit_flag, below_limit_flag,
           din0_level, din1_level, dout0_state, dout1_state, err_code_valid
  );
  modport host (
    output refresh, load_preset_cmd, clear_count_cmd, load_value_signed, count_type_select,
           high_limit_setting, low_limit_setting, index_and_errgen_cfg, out_mode_select,
           dout0_manual_level, dout1_manual_level, err_dout0_level, err_dout1_level,
           auto_dout0_level, auto_dout1_level,
    input  signed_count_value, wrap_count_value, above_limit_flag, below_limit_flag,
           din0_level, din1_level, dout0_state, dout1_state, err_code_valid
  );
endinterface

// [verilog/qcc_channel.sv]
// qcc_channel: one 32-bit counter channel, device end of the exchange
// assumes: count steps and index pulse from an already decoded, synchronous source;
// digital input pins are asynchronous and synchronised here
`timescale 1ns/1ps
module qcc_channel
  import qcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  qcc_if.dev              link,
  input  wire logic       step_up,
  input  wire logic       step_down,
  input  wire logic       index_pulse,
  input  wire logic       din0_pin,
  input  wire logic       din1_pin,
  output logic            dout0_pin,
  output logic            dout1_pin,
  output logic            err_store_we,
  output logic [1:0]      err_store_code
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count_q,   count_d;
  logic             ovf_q,     ovf_d;
  logic             udf_q,     udf_d;
  logic             prst_q,    prst_d;
  logic             rst_q,     rst_d;
  logic [1:0]       din_s1_q,  din_s2_q;
  logic             dout0_q,   dout0_d;
  logic             dout1_q,   dout1_d;
  logic             errv_q,    errv_d;
  logic             we_q,      we_d;
  logic [1:0]       code_q,    code_d;

  logic [CNT_W-1:0] circ_lim;
  logic [CNT_W-1:0] lin_hi;
  logic [CNT_W-1:0] lin_lo;
  logic             idx_en;
  logic             err_en;
  logic             frozen;
  qcc_step_t        step;

  // ---------------------------------------------------------------
  // effective limits
  // ---------------------------------------------------------------
  always_comb begin
    // circular limit: zero selects the maximum
    circ_lim = (link.high_limit_setting == ZERO32) ? CIRC_MAX : link.high_limit_setting;
    if (link.high_limit_setting == ZERO32 || link.low_limit_setting == ZERO32) begin
      lin_hi = LIN_MAX;
      lin_lo = LIN_MIN;
    end else begin
      lin_hi = link.high_limit_setting;
      lin_lo = link.low_limit_setting;
    end
    idx_en = (link.index_and_errgen_cfg[CFG_IDX_MSB:CFG_IDX_LSB] == CFG_FIELD_ON);
    err_en = (link.index_and_errgen_cfg[CFG_ERR_MSB:CFG_ERR_LSB] == CFG_FIELD_ON);
    frozen = ovf_q || udf_q;
    if (step_up && !step_down) begin
      step = QCC_STEP_UP;
    end else if (step_down && !step_up) begin
      step = QCC_STEP_DOWN;
    end else begin
      step = QCC_STEP_NONE;
    end
  end

  // ---------------------------------------------------------------
  // counter next state
  // ---------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    ovf_d   = ovf_q;
    udf_d   = udf_q;
    prst_d  = prst_q;
    rst_d   = rst_q;
    we_d    = 1'b0;
    code_d  = code_q;
    errv_d  = errv_q;
    if (link.refresh) begin
      prst_d = link.load_preset_cmd;
      rst_d  = link.clear_count_cmd;
    end
    if (link.count_type_select == TYPE_CIRCULAR) begin
      ovf_d = 1'b0;
      udf_d = 1'b0;
      unique case (step)
        QCC_STEP_UP:   count_d = (count_q >= circ_lim) ? ZERO32 : count_q + ONE32;
        QCC_STEP_DOWN: count_d = (count_q == ZERO32 || count_q > circ_lim) ? circ_lim : count_q - ONE32;
        QCC_STEP_NONE: count_d = count_q;
      endcase
    end else if (!frozen) begin
      unique case (step)
        QCC_STEP_UP: begin
          if ($signed(count_q) >= $signed(lin_hi)) begin
            ovf_d = 1'b1;
          end else begin
            count_d = count_q + ONE32;
          end
        end
        QCC_STEP_DOWN: begin
          if ($signed(count_q) <= $signed(lin_lo)) begin
            udf_d = 1'b1;
          end else begin
            count_d = count_q - ONE32;
          end
        end
        QCC_STEP_NONE: count_d = count_q;
      endcase
      if ((ovf_d || udf_d) && err_en) begin
        we_d   = 1'b1;
        code_d = {udf_d, ovf_d};
      end
      if (ovf_d || udf_d) begin
        errv_d = 1'b1;
      end
    end
    if (idx_en && index_pulse) begin
      count_d = ZERO32;
    end
    if (link.refresh && link.load_preset_cmd && !prst_q) begin
      count_d = link.load_value_signed;
      ovf_d   = 1'b0;
      udf_d   = 1'b0;
      errv_d  = 1'b0;
    end
    if (link.refresh && link.clear_count_cmd && !rst_q) begin
      count_d = ZERO32;
      ovf_d   = 1'b0;
      udf_d   = 1'b0;
      errv_d  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // digital outputs
  // ---------------------------------------------------------------
  always_comb begin
    if (errv_q) begin
      dout0_d = link.err_dout0_level;
      dout1_d = link.err_dout1_level;
    end else if (link.out_mode_select == OUT_MANUAL) begin
      dout0_d = link.dout0_manual_level;
      dout1_d = link.dout1_manual_level;
    end else begin
      dout0_d = link.auto_dout0_level;
      dout1_d = link.auto_dout1_level;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_q  <= ZERO32;
      ovf_q    <= 1'b0;
      udf_q    <= 1'b0;
      prst_q   <= 1'b0;
      rst_q    <= 1'b0;
      din_s1_q <= 2'b00;
      din_s2_q <= 2'b00;
      dout0_q  <= 1'b0;
      dout1_q  <= 1'b0;
      errv_q   <= 1'b0;
      we_q     <= 1'b0;
      code_q   <= 2'b00;
    end else begin
      count_q  <= count_d;
      ovf_q    <= ovf_d;
      udf_q    <= udf_d;
      prst_q   <= prst_d;
      rst_q    <= rst_d;
      din_s1_q <= {din1_pin, din0_pin};
      din_s2_q <= din_s1_q;
      dout0_q  <= dout0_d;
      dout1_q  <= dout1_d;
      errv_q   <= errv_d;
      we_q     <= we_d;
      code_q   <= code_d;
    end
  end

  // ---------------------------------------------------------------
  // status to host
  // ---------------------------------------------------------------
  assign link.signed_count_value = count_q;
  assign link.wrap_count_value   = count_q;
  assign link.above_limit_flag   = ovf_q;
  assign link.below_limit_flag   = udf_q;
  assign link.din0_level         = din_s2_q[0];
  assign link.din1_level         = din_s2_q[1];
  assign link.dout0_state        = dout0_q;
  assign link.dout1_state        = dout1_q;
  assign link.err_code_valid     = errv_q;
  assign dout0_pin               = dout0_q;
  assign dout1_pin               = dout1_q;
  assign err_store_we            = we_q;
  assign err_store_code          = code_q;

endmodule

// [verilog/qcc_host.sv]
// qcc_host: host controller end, generates refresh and holds exchanged variables
// assumes: user side is logic on the same clock
`timescale 1ns/1ps
module qcc_host
  import qcc_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = 16
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  qcc_if.host                    link,
  input  wire logic              preset_req,
  input  wire logic              clear_req,
  input  wire logic [CNT_W-1:0]  preset_value,
  input  wire logic              cfg_type,
  input  wire logic [CNT_W-1:0]  cfg_high,
  input  wire logic [CNT_W-1:0]  cfg_low,
  input  wire logic [CFG_W-1:0]  cfg_word,
  input  wire logic              cfg_out_mode,
  input  wire logic [1:0]        cfg_manual,
  input  wire logic [1:0]        cfg_err_out,
  input  wire logic [1:0]        cfg_auto_out,
  output logic                   busy,
  output logic [CNT_W-1:0]       count_value,
  output logic [1:0]             limit_flags
);

  // ---------------------------------------------------------------
  // refresh timer
  // ---------------------------------------------------------------
  logic [15:0]      tick_q, tick_d;
  logic             refresh;
  qcc_hstate_t      st_q,   st_d;
  logic             cmd_q,  cmd_d;
  logic             kind_q, kind_d;
  logic [CNT_W-1:0] pval_q, pval_d;
  logic [CNT_W-1:0] cnt_q,  cnt_d;
  logic [1:0]       flg_q,  flg_d;

  always_comb begin
    refresh = (tick_q == 16'(REFRESH_CYCLES - 1));
    tick_d  = refresh ? 16'h0000 : tick_q + 16'h0001;
    st_d    = st_q;
    cmd_d   = cmd_q;
    kind_d  = kind_q;
    pval_d  = pval_q;
    cnt_d   = refresh ? link.signed_count_value : cnt_q;
    flg_d   = refresh ? {link.below_limit_flag, link.above_limit_flag} : flg_q;
    unique case (st_q)
      QCC_H_IDLE: begin
        if (preset_req || clear_req) begin
          pval_d = preset_req ? preset_value : pval_q;
          kind_d = preset_req;
          st_d   = QCC_H_ARM;
        end
      end
      QCC_H_ARM: begin
        if (refresh) begin
          cmd_d = 1'b1;
          st_d  = QCC_H_CLEAR;
        end
      end
      QCC_H_CLEAR: begin
        if (refresh) begin
          cmd_d = 1'b0;
          st_d  = QCC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_q <= 16'h0000;
      st_q   <= QCC_H_IDLE;
      cmd_q  <= 1'b0;
      kind_q <= 1'b0;
      pval_q <= ZERO32;
      cnt_q  <= ZERO32;
      flg_q  <= 2'b00;
    end else begin
      tick_q <= tick_d;
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      kind_q <= kind_d;
      pval_q <= pval_d;
      cnt_q  <= cnt_d;
      flg_q  <= flg_d;
    end
  end

  // limits passed as given by user
  assign link.refresh              = refresh;
  assign link.load_preset_cmd      = cmd_q && kind_q;
  assign link.clear_count_cmd      = cmd_q && !kind_q;
  assign link.load_value_signed    = pval_q;
  assign link.count_type_select    = cfg_type;
  assign link.high_limit_setting   = cfg_high;
  assign link.low_limit_setting    = cfg_low;
  assign link.index_and_errgen_cfg = cfg_word;
  assign link.out_mode_select      = cfg_out_mode;
  assign link.dout0_manual_level   = cfg_manual[0];
  assign link.dout1_manual_level   = cfg_manual[1];
  assign link.err_dout0_level      = cfg_err_out[0];
  assign link.err_dout1_level      = cfg_err_out[1];
  assign link.auto_dout0_level     = cfg_auto_out[0];
  assign link.auto_dout1_level     = cfg_auto_out[1];
  assign busy                      = (st_q != QCC_H_IDLE);
  assign count_value               = cnt_q;
  assign limit_flags               = flg_q;

endmodule

// [bench/qcc_properties.sv]
// checks on the exchange between the host end and the counter channel
// assumes: one clock, sync active-low reset, refresh made by the host end
`timescale 1ns/1ps
module qcc_properties
  import qcc_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = 16
)
(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             refresh,
  input wire logic             load_preset_cmd,
  input wire logic             clear_count_cmd,
  input wire logic [CNT_W-1:0] load_value_signed,
  input wire logic             count_type_select,
  input wire logic [CNT_W-1:0] high_limit_setting,
  input wire logic [CFG_W-1:0] index_and_errgen_cfg,
  input wire logic             out_mode_select,
  input wire logic             dout0_manual_level,
  input wire logic             err_dout0_level,
  input wire logic             auto_dout0_level,
  input wire logic [CNT_W-1:0] wrap_count_value,
  input wire logic             above_limit_flag,
  input wire logic             below_limit_flag,
  input wire logic             dout0_state
);
  // ------------------------------
  // helpers
  // ------------------------------
  logic        prst_q, prst_d, clr_q, clr_d, seen_q, seen_d;
  logic [15:0] gap_q, gap_d;
  logic        prst_rise, clr_rise, nocmd, flag_any, circ_ok, err_on, idx_off;
  assign prst_rise = refresh && load_preset_cmd && !prst_q;
  assign clr_rise  = refresh && clear_count_cmd && !clr_q;
  assign nocmd     = !prst_rise && !clr_rise;
  assign flag_any  = above_limit_flag || below_limit_flag;
  assign circ_ok   = (count_type_select == TYPE_CIRCULAR) && !flag_any;
  assign err_on    = index_and_errgen_cfg[CFG_ERR_MSB:CFG_ERR_LSB] == CFG_FIELD_ON;
  assign idx_off   = index_and_errgen_cfg[CFG_IDX_MSB:CFG_IDX_LSB] != CFG_FIELD_ON;
  always_comb begin
    prst_d = refresh ? load_preset_cmd : prst_q;
    clr_d  = refresh ? clear_count_cmd : clr_q;
    seen_d = seen_q || refresh;
    gap_d  = refresh ? 16'h0000 : gap_q + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prst_q <= 1'b0;
      clr_q  <= 1'b0;
      seen_q <= 1'b0;
      gap_q  <= 16'h0000;
    end else begin
      prst_q <= prst_d;
      clr_q  <= clr_d;
      seen_q <= seen_d;
      gap_q  <= gap_d;
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence cmd_s;
    prst_rise || clr_rise;
  endsequence
  sequence calm_s;
    circ_ok [*2];
  endsequence
  sequence fault_s;
    (flag_any && count_type_select == TYPE_LINEAR && err_on) [*3];
  endsequence
  refresh_gap_a: assert property (refresh && seen_q |-> gap_q == REFRESH_CYCLES - 1)
    else $error("refresh spacing off");
  preset_load_a: assert property (prst_rise && !clr_rise |=> wrap_count_value == $past(load_value_signed))
    else $error("preset value not loaded");
  clear_load_a: assert property (clr_rise |=> wrap_count_value == ZERO32)
    else $error("count not cleared");
  flag_clear_a: assert property (cmd_s |=> !flag_any)
    else $error("flag not cleared by command");
  flag_hold_a: assert property (flag_any && nocmd |=> $stable(above_limit_flag) && $stable(below_limit_flag))
    else $error("limit flag changed without command");
  count_freeze_a: assert property (flag_any && count_type_select == TYPE_LINEAR && nocmd && idx_off
    |=> $stable(wrap_count_value))
    else $error("count moved while frozen");
  manual_out_a: assert property (calm_s ##0 out_mode_select == OUT_MANUAL
    |=> dout0_state == $past(dout0_manual_level))
    else $error("manual output not followed");
  auto_out_a: assert property (calm_s ##0 out_mode_select == OUT_AUTO
    |=> dout0_state == $past(auto_dout0_level))
    else $error("auto output not followed");
  err_force_a: assert property (fault_s |-> dout0_state == $past(err_dout0_level))
    else $error("error output level not forced");
  circ_range_a: assert property (count_type_select == TYPE_CIRCULAR && high_limit_setting != ZERO32
    && wrap_count_value <= high_limit_setting && nocmd |=> wrap_count_value <= $past(high_limit_setting))
    else $error("circular count above limit");
endmodule

// [bench/quad_counter_channel_core_test.sv]
// host end and counter channel joined; random and corner stimulus at the user sides
// assumes: qcc_pkg, qcc_if, qcc_host, qcc_channel and qcc_properties compiled first
`timescale 1ns/1ps
module quad_counter_channel_core_test;
  import qcc_pkg::*;
  localparam int unsigned RC = 4;
  logic             clk, nrst, preset_req, clear_req, cfg_type, cfg_out_mode, busy;
  logic             step_up, step_down, index_pulse, din0_pin, din1_pin, dout0_pin, dout1_pin, err_store_we;
  logic [1:0]       cfg_manual, cfg_err_out, cfg_auto_out, limit_flags, err_store_code, err_code;
  logic [CNT_W-1:0] preset_value, cfg_high, cfg_low, count_value, exp_cnt;
  logic [CFG_W-1:0] cfg_word;
  int               err_total = 0, checked = 0, cycles = 0, err_hits = 0;
  qcc_if link();
  qcc_host #(.REFRESH_CYCLES(RC)) qcc_host_i (.clk(clk), .nrst(nrst), .link(link),
    .preset_req(preset_req), .clear_req(clear_req), .preset_value(preset_value), .cfg_type(cfg_type),
    .cfg_high(cfg_high), .cfg_low(cfg_low), .cfg_word(cfg_word), .cfg_out_mode(cfg_out_mode),
    .cfg_manual(cfg_manual), .cfg_err_out(cfg_err_out), .cfg_auto_out(cfg_auto_out), .busy(busy),
    .count_value(count_value), .limit_flags(limit_flags));
  qcc_channel qcc_channel_i (.clk(clk), .nrst(nrst), .link(link), .step_up(step_up), .step_down(step_down),
    .index_pulse(index_pulse), .din0_pin(din0_pin), .din1_pin(din1_pin), .dout0_pin(dout0_pin),
    .dout1_pin(dout1_pin), .err_store_we(err_store_we), .err_store_code(err_store_code));
  qcc_properties #(.REFRESH_CYCLES(RC)) qcc_properties_i (.clk(clk), .nrst(nrst), .refresh(link.refresh),
    .load_preset_cmd(link.load_preset_cmd), .clear_count_cmd(link.clear_count_cmd),
    .load_value_signed(link.load_value_signed), .count_type_select(link.count_type_select),
    .high_limit_setting(link.high_limit_setting), .index_and_errgen_cfg(link.index_and_errgen_cfg),
    .out_mode_select(link.out_mode_select), .dout0_manual_level(link.dout0_manual_level),
    .err_dout0_level(link.err_dout0_level), .auto_dout0_level(link.auto_dout0_level),
    .wrap_count_value(link.wrap_count_value), .above_limit_flag(link.above_limit_flag),
    .below_limit_flag(link.below_limit_flag), .dout0_state(link.dout0_state));
  // ------------------------------
  // clock, monitor, tasks
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (err_store_we === 1'b1) begin
      err_hits++;
      err_code = err_store_code;
    end
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic host_cmd(input logic clr, input logic nag);
    int k;
    @(negedge clk);
    preset_req = !clr;
    clear_req = clr;
    @(negedge clk);
    preset_req = 1'b0;
    clear_req = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 64) begin
      @(negedge clk);
      k++;
      clear_req = nag && (k == 2);
    end
    clear_req = 1'b0;
    cyc(3 * RC);
  endtask
  task automatic step(input logic up, input int n);
    @(negedge clk);
    step_up = up;
    step_down = !up;
    cyc(n);
    step_up = 1'b0;
    step_down = 1'b0;
  endtask
  function automatic logic [CNT_W-1:0] circ_nxt(input logic [CNT_W-1:0] v, input logic up, input logic [CNT_W-1:0] l);
    if (up) return (v >= l) ? ZERO32 : v + ONE32;
    return (v == ZERO32) ? l : v - ONE32;
  endfunction
  function automatic logic [CNT_W-1:0] rpos();
    return (32'($urandom) >> 1) | ONE32;
  endfunction
  task automatic lin_run(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] lo, input logic up, input logic eg);
    logic [CNT_W-1:0] eh, el;
    eh = (hi == ZERO32 || lo == ZERO32) ? LIN_MAX : hi;
    el = (hi == ZERO32 || lo == ZERO32) ? LIN_MIN : lo;
    cfg_type = TYPE_LINEAR;
    cfg_high = hi;
    cfg_low = lo;
    cfg_word = eg ? 16'h0010 : CFG_RESET;
    cfg_out_mode = OUT_MANUAL;
    cfg_err_out = 2'($urandom);
    cfg_manual = ~cfg_err_out;
    preset_value = up ? eh - ONE32 : el + ONE32;
    host_cmd(1'b0, 1'b0);
    err_hits = 0;
    step(up, 3);
    step(!up, 2);
    cyc(2 * RC + 2);
    check(link.wrap_count_value, up ? eh : el);
    check(link.signed_count_value, up ? eh : el);
    check(32'(link.err_code_valid), 32'h0000_0001);
    check(32'(limit_flags), up ? 32'h0000_0001 : 32'h0000_0002);
    check(32'(err_hits), 32'(eg));
    if (eg) check(32'(err_code), up ? 32'h0000_0001 : 32'h0000_0002);
    if (eg) check(32'({dout1_pin, dout0_pin}), 32'(cfg_err_out));
    host_cmd(1'b1, 1'b0);
    check(link.wrap_count_value, ZERO32);
    check(32'({link.below_limit_flag, link.above_limit_flag}), ZERO32);
    check(32'(link.err_code_valid), ZERO32);
  endtask
  task automatic circ_run(input logic [CNT_W-1:0] lim);
    logic [CNT_W-1:0] el;
    el = (lim == ZERO32) ? CIRC_MAX : lim;
    cfg_type = TYPE_CIRCULAR;
    cfg_high = lim;
    preset_value = el - ONE32;
    host_cmd(1'b0, 1'b0);
    exp_cnt = preset_value;
    for (int i = 0; i < 5; i++) exp_cnt = circ_nxt(exp_cnt, i < 3, el);
    step(1'b1, 3);
    step(1'b0, 2);
    cyc(2);
    check(link.wrap_count_value, exp_cnt);
    check(32'({link.below_limit_flag, link.above_limit_flag}), ZERO32);
    for (int i = 0; i < 2; i++) begin
      cfg_word = i ? {12'h000, CFG_FIELD_ON} : CFG_RESET;
      @(negedge clk);
      index_pulse = 1'b1;
      @(negedge clk);
      index_pulse = 1'b0;
      cyc(2);
      check(link.wrap_count_value, i ? ZERO32 : exp_cnt);
    end
  endtask
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    void'($urandom(32'h58db));
    {nrst, preset_req, clear_req, cfg_type, cfg_out_mode, step_up, step_down, index_pulse} = 8'h00;
    {din0_pin, din1_pin, cfg_manual, cfg_err_out, cfg_auto_out, cfg_word} = 24'h00_0000;
    {preset_value, cfg_high, cfg_low} = 96'h0;
    cyc(4);
    nrst = 1'b1;
    cyc(2);
    check(link.wrap_count_value, ZERO32);
    check(32'({busy, limit_flags, dout1_pin, dout0_pin}), ZERO32);
    cfg_type = TYPE_LINEAR;
    preset_value = 32'($urandom);
    host_cmd(1'b0, 1'b1);
    check(count_value, preset_value);
    check(link.wrap_count_value, preset_value);
    lin_run(rpos(), ~rpos(), 1'b1, 1'b1);
    lin_run(rpos(), ~rpos(), 1'b0, 1'b1);
    lin_run(ZERO32, ~rpos(), 1'b1, 1'b0);
    lin_run(rpos(), ZERO32, 1'b0, 1'b0);
    circ_run(rpos());
    circ_run(ZERO32);
    circ_run(ONE32);
    for (int v = 0; v < 4; v++) begin
      {din1_pin, din0_pin} = 2'(v);
      cfg_manual = 2'(v);
      cfg_auto_out = ~2'(v);
      cfg_out_mode = OUT_MANUAL;
      cyc(3);
      check(32'({dout1_pin, dout0_pin}), 32'(v));
      check(32'({link.dout1_state, link.dout0_state}), 32'(v));
      check(32'({link.din1_level, link.din0_level}), 32'(v));
      cfg_out_mode = OUT_AUTO;
      cyc(2);
      check(32'({dout1_pin, dout0_pin}), 32'(cfg_auto_out));
    end
    final_report();
  end
endmodule
